// *** src/sbdsr_regs.v ***
// What this block does
// RQ1: hold port 2 default egress priority
// RQ2: hold port 2 default VLAN ID, reset one
// RQ3: count rate-limit drops per port, reset zero
// RQ4: reading a drop counter clears it
// RQ5: drop counters saturate at all ones
// RQ6: mask bit, set at reset, blocks interrupts
// RQ7: mask gates only the interrupt output
// RQ8: two drop record slots, A and B
// RQ9: slot B reason code, read clears
// RQ10: codes 0000 broadcast limit, 0100 no destination
// RQ11: codes 0001 red, 0010 buffers, 0011 descriptors
// RQ12: codes 0101 receive error, 0110 drop limit
// RQ13: code 1001 yellow drop; others reserved
// RQ14: slot B source port, read clears
// RQ15: slot B pending flag qualifies its fields
// RQ16: slot A valid flag, reason, port fields
// RQ17: interrupt when any flag set, unmasked
// RQ18: fill A, then B, then drop records
`include "sbdsr_consts.vh"
module sbdsr_regs
(
    input wire clk_sys_i,
    input wire reset_i,
    input wire [13:0] reg_index_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    input wire [2:0] rate_drop_i,
    input wire drop_event_i,
    input wire [3:0] drop_reason_i,
    input wire [1:0] drop_port_i,
    output wire [2:0] egress_priority_o,
    output wire [11:0] egress_vlan_id_o,
    output wire irq_o
);
    reg [2:0] prio_reg;
    reg [11:0] vid_reg;
    reg mask_reg;
    reg a_valid_reg;
    reg [3:0] a_reason_reg;
    reg [1:0] a_port_reg;
    reg b_pend_reg;
    reg [3:0] b_reason_reg;
    reg [1:0] b_port_reg;
    reg a_valid_next;
    reg [3:0] a_reason_next;
    reg [1:0] a_port_next;
    reg b_pend_next;
    reg [3:0] b_reason_next;
    reg [1:0] b_port_next;
    reg [31:0] rdata_next;
    reg [2:0] prio_next;
    reg [11:0] vid_next;
    reg mask_next;
    wire [31:0] cnt0;
    wire [31:0] cnt1;
    wire [31:0] cnt2;
    wire [31:0] pend_word;
    wire rd_cnt0;
    wire rd_cnt1;
    wire rd_cnt2;
    wire rd_pend;
    wire wr_vlan;
    wire wr_mask;

    // address decode of read strobes
    function sel;
        input [13:0] idx;
        input [13:0] target;
        begin
            sel = (idx == target);
        end
    endfunction

    assign rd_cnt0 = reg_rd_i && sel(reg_index_i, `SBDSR_IDX_CNT0);
    assign rd_cnt1 = reg_rd_i && sel(reg_index_i, `SBDSR_IDX_CNT1);
    assign rd_cnt2 = reg_rd_i && sel(reg_index_i, `SBDSR_IDX_CNT2);
    assign rd_pend = reg_rd_i && sel(reg_index_i, `SBDSR_IDX_PEND);

    // write strobes of the two writable registers
    assign wr_vlan = reg_wr_i && sel(reg_index_i, `SBDSR_IDX_VLAN2);
    assign wr_mask = reg_wr_i && sel(reg_index_i, `SBDSR_IDX_MASK);

    // one counter per source port
    sbdsr_drop_counter u_cnt0
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .drop_i(rate_drop_i[0]),
        .read_clear_i(rd_cnt0),
        .count_o(cnt0)
    );
    sbdsr_drop_counter u_cnt1
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .drop_i(rate_drop_i[1]),
        .read_clear_i(rd_cnt1),
        .count_o(cnt1)
    );
    sbdsr_drop_counter u_cnt2
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .drop_i(rate_drop_i[2]),
        .read_clear_i(rd_cnt2),
        .count_o(cnt2)
    );

    // egress tagging defaults
    assign egress_priority_o = prio_reg; // RQ1
    assign egress_vlan_id_o = vid_reg; // RQ2

    // pending word layout, upper bits read zero
    assign pend_word = {18'h00000, b_reason_reg, b_port_reg, b_pend_reg,
                        a_reason_reg, a_port_reg, a_valid_reg}; // RQ8

    // interrupt from either flag, gated by mask only
    assign irq_o = (a_valid_reg || b_pend_reg) && !mask_reg; // RQ17 RQ6 RQ7

    // writable fields; reserved bits of a write are dropped
    always @*
    begin
        prio_next = prio_reg;
        vid_next = vid_reg;
        mask_next = mask_reg;
        if (wr_vlan)
        begin
            prio_next = reg_wdata_i[`SBDSR_PRIO_HI:`SBDSR_PRIO_LO]; // RQ1
            vid_next = reg_wdata_i[`SBDSR_VID_HI:`SBDSR_VID_LO]; // RQ2
        end
        if (wr_mask)
        begin
            mask_next = reg_wdata_i[0]; // RQ6
        end
    end

    // slot update: read clears, a new event wins over the clear
    always @*
    begin
        a_valid_next = a_valid_reg;
        a_reason_next = a_reason_reg;
        a_port_next = a_port_reg;
        b_pend_next = b_pend_reg;
        b_reason_next = b_reason_reg;
        b_port_next = b_port_reg;
        if (rd_pend)
        begin
            a_valid_next = 1'b0; // RQ16
            a_reason_next = 4'h0;
            a_port_next = 2'h0;
            b_pend_next = 1'b0; // RQ15
            b_reason_next = 4'h0; // RQ9
            b_port_next = 2'h0; // RQ14
        end
        // reason codes pass through as given, see encodings
        if (drop_event_i) // RQ10 RQ11 RQ12 RQ13
        begin
            if (!a_valid_next) // RQ18
            begin
                a_valid_next = 1'b1;
                a_reason_next = drop_reason_i; // RQ16
                a_port_next = drop_port_i;
            end
            else if (!b_pend_next) // RQ18
            begin
                b_pend_next = 1'b1; // RQ15
                b_reason_next = drop_reason_i; // RQ9
                b_port_next = drop_port_i; // RQ14
            end
            // both slots full: the record is lost until read
        end
    end

    // read data mux, unmapped reads return zero
    always @*
    begin
        rdata_next = 32'h00000000;
        case (reg_index_i)
            `SBDSR_IDX_VLAN2: rdata_next = {17'h00000, prio_reg, vid_reg};
            `SBDSR_IDX_CNT0: rdata_next = cnt0; // RQ4
            `SBDSR_IDX_CNT1: rdata_next = cnt1; // RQ4
            `SBDSR_IDX_CNT2: rdata_next = cnt2; // RQ4
            `SBDSR_IDX_MASK: rdata_next = {31'h00000000, mask_reg};
            `SBDSR_IDX_PEND: rdata_next = pend_word;
            default: rdata_next = 32'h00000000;
        endcase
    end

    // register state
    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            prio_reg <= `SBDSR_PRIO_RST; // RQ1
            vid_reg <= `SBDSR_VID_RST; // RQ2
            mask_reg <= `SBDSR_MASK_RST; // RQ6
            a_valid_reg <= 1'b0;
            a_reason_reg <= 4'h0;
            a_port_reg <= 2'h0;
            b_pend_reg <= 1'b0;
            b_reason_reg <= 4'h0;
            b_port_reg <= 2'h0;
            reg_rdata_o <= 32'h00000000;
        end
        else
        begin
            prio_reg <= prio_next; // RQ1
            vid_reg <= vid_next; // RQ2
            mask_reg <= mask_next; // RQ6
            a_valid_reg <= a_valid_next;
            a_reason_reg <= a_reason_next;
            a_port_reg <= a_port_next;
            b_pend_reg <= b_pend_next;
            b_reason_reg <= b_reason_next;
            b_port_reg <= b_port_next;
            // read data captured on a read strobe, held otherwise
            if (reg_rd_i)
                reg_rdata_o <= rdata_next;
        end
    end
endmodule

// *** src/sbdsr_consts.vh ***
`ifndef SBDSR_CONSTS_VH
`define SBDSR_CONSTS_VH
// register indices, byte address is four times the index
`define SBDSR_IDX_VLAN2 14'h1C15
`define SBDSR_IDX_CNT0 14'h1C16
`define SBDSR_IDX_CNT1 14'h1C17
`define SBDSR_IDX_CNT2 14'h1C18
`define SBDSR_IDX_MASK 14'h1C20
`define SBDSR_IDX_PEND 14'h1C21
// vlan register fields
`define SBDSR_PRIO_HI 14
`define SBDSR_PRIO_LO 12
`define SBDSR_VID_HI 11
`define SBDSR_VID_LO 0
`define SBDSR_VID_RST 12'h001
`define SBDSR_PRIO_RST 3'h0
// counters
`define SBDSR_CNT_RST 32'h00000000
`define SBDSR_CNT_MAX 32'hFFFFFFFF
// mask reset
`define SBDSR_MASK_RST 1'b1
// pending register fields
`define SBDSR_B_REASON_LO 10
`define SBDSR_B_PORT_LO 8
`define SBDSR_B_PEND_BIT 7
`define SBDSR_A_REASON_LO 3
`define SBDSR_A_PORT_LO 1
`define SBDSR_A_VALID_BIT 0
// drop reason codes
`define SBDSR_RSN_BCAST_LIMIT 4'h0
`define SBDSR_RSN_RED 4'h1
`define SBDSR_RSN_NO_BUF 4'h2
`define SBDSR_RSN_NO_DESC 4'h3
`define SBDSR_RSN_NO_DEST 4'h4
`define SBDSR_RSN_RX_ERR 4'h5
`define SBDSR_RSN_DROP_LIMIT 4'h6
`define SBDSR_RSN_YELLOW 4'h9
// source port codes
`define SBDSR_PORT0 2'h0
`define SBDSR_PORT1 2'h1
`define SBDSR_PORT2 2'h2
`endif

// *** src/sbdsr_drop_counter.v ***
`include "sbdsr_consts.vh"
// saturating read-clear drop counter for one port
module sbdsr_drop_counter
(
    input wire clk_sys_i,
    input wire reset_i,
    input wire drop_i,
    input wire read_clear_i,
    output reg [31:0] count_o
);
    reg [31:0] count_next;

    // read clears; a drop in the read cycle starts the new count at one
    always @*
    begin
        count_next = count_o;
        if (read_clear_i)
        begin
            count_next = drop_i ? 32'h00000001 : `SBDSR_CNT_RST; // RQ4
        end
        else if (drop_i && count_o != `SBDSR_CNT_MAX) // RQ5
        begin
            count_next = count_o + 32'h00000001; // RQ3
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
            count_o <= `SBDSR_CNT_RST; // RQ3
        else
            count_o <= count_next;
    end
endmodule

// *** sim/sbdsr_checker.sv ***
`include "sbdsr_consts.vh"
// port-level checks of the drop status slice
module sbdsr_checker
(
    input wire clk_sys_i,
    input wire reset_i,
    input wire [13:0] reg_index_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_wdata_i,
    input wire [31:0] reg_rdata_o,
    input wire [2:0] rate_drop_i,
    input wire drop_event_i,
    input wire [2:0] egress_priority_o,
    input wire [11:0] egress_vlan_id_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // vlan write strobe
    wire wv = reg_wr_i && reg_index_i == `SBDSR_IDX_VLAN2;
    // reads with no fresh event in the same cycle
    sequence s_rd_cnt0;
        reg_rd_i && reg_index_i == `SBDSR_IDX_CNT0 && !rate_drop_i[0];
    endsequence
    sequence s_rd_pend;
        reg_rd_i && reg_index_i == `SBDSR_IDX_PEND && !drop_event_i;
    endsequence
    property p_rst_irq;
        $fell(reset_i) |-> !irq_o;
    endproperty
    property p_rst_vlan;
        $fell(reset_i) |-> egress_vlan_id_o == 12'h001
            && egress_priority_o == 3'h0;
    endproperty
    property p_vid_wr;
        wv |=> egress_vlan_id_o == $past(reg_wdata_i[11:0]);
    endproperty
    property p_prio_wr;
        wv |=> egress_priority_o == $past(reg_wdata_i[14:12]);
    endproperty
    property p_vlan_hold;
        !wv |=> $stable(egress_vlan_id_o) && $stable(egress_priority_o);
    endproperty
    property p_mask_on;
        reg_wr_i && reg_index_i == `SBDSR_IDX_MASK && reg_wdata_i[0]
            |=> !irq_o;
    endproperty
    // two reads with one quiet cycle between them
    property p_cnt_clr;
        s_rd_cnt0 ##1 !rate_drop_i[0] ##1 s_rd_cnt0
            |=> reg_rdata_o == 32'h00000000;
    endproperty
    property p_pend_clr;
        s_rd_pend ##1 !drop_event_i ##1 s_rd_pend
            |=> reg_rdata_o == 32'h00000000;
    endproperty
    a_rst_irq: assert property (p_rst_irq)
        else $error("irq high after reset");
    a_rst_vlan: assert property (p_rst_vlan)
        else $error("vlan outputs not at reset value");
    a_vid_wr: assert property (p_vid_wr)
        else $error("vlan id not written");
    a_prio_wr: assert property (p_prio_wr)
        else $error("priority not written");
    a_vlan_hold: assert property (p_vlan_hold)
        else $error("vlan outputs moved without write");
    a_mask_on: assert property (p_mask_on)
        else $error("irq high while masked");
    a_cnt_clr: assert property (p_cnt_clr)
        else $error("counter not cleared by read");
    a_pend_clr: assert property (p_pend_clr)
        else $error("pending not cleared by read");
endmodule

// *** sim/sbdsr_regs_tb.sv ***
`include "sbdsr_consts.vh"
module sbdsr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0;
    logic reset_i = 1;
    logic [13:0] reg_index_i = 0;
    logic reg_wr_i = 0;
    logic reg_rd_i = 0;
    logic [31:0] reg_wdata_i = 0;
    logic [2:0] rate_drop_i = 0;
    logic drop_event_i = 0;
    logic [3:0] drop_reason_i = 0;
    logic [1:0] drop_port_i = 0;
    logic [1:0] pa;
    logic [1:0] pb;
    logic [3:0] rsn [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
    wire [31:0] reg_rdata_o;
    wire [2:0] egress_priority_o;
    wire [11:0] egress_vlan_id_o;
    wire irq_o;
    int n_errors = 0;
    int n_checks = 0;
    sbdsr_regs dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reg_index_i(reg_index_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .rate_drop_i(rate_drop_i),
        .drop_event_i(drop_event_i), .drop_reason_i(drop_reason_i),
        .drop_port_i(drop_port_i), .egress_priority_o(egress_priority_o),
        .egress_vlan_id_o(egress_vlan_id_o), .irq_o(irq_o));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one bus cycle, strobe for one edge, then an idle edge
    task wr(input logic [13:0] i, input logic [31:0] d);
        reg_index_i <= i;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task rd(input logic [13:0] i, input logic [31:0] e);
        reg_index_i <= i;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(reg_rdata_o, e);
        @(posedge clk_sys_i);
    endtask
    task ev(input logic [3:0] r, input logic [1:0] p);
        drop_reason_i <= r;
        drop_port_i <= p;
        drop_event_i <= 1'b1;
        @(posedge clk_sys_i);
        drop_event_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // hang guard
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        n_errors++;
        test_done;
    end
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(`SBDSR_IDX_VLAN2, 32'h00000001);
        rd(`SBDSR_IDX_CNT1, 32'h0);
        rd(`SBDSR_IDX_MASK, 32'h1);
        rd(`SBDSR_IDX_PEND, 32'h0);
        rd(14'h1C19, 32'h0);
        wr(`SBDSR_IDX_VLAN2, 32'hFFFFFFFF);
        rd(`SBDSR_IDX_VLAN2, 32'h00007FFF);
        chk({17'h0, egress_priority_o, egress_vlan_id_o}, 32'h7FFF);
        $display("test vlan done");
        // ports 0 and 2 drop five, port 1 two
        rate_drop_i <= 3'h5;
        repeat (5) @(posedge clk_sys_i);
        rate_drop_i <= 3'h2;
        repeat (2) @(posedge clk_sys_i);
        rate_drop_i <= 3'h0;
        rd(`SBDSR_IDX_CNT0, 32'h5);
        rd(`SBDSR_IDX_CNT0, 32'h0);
        rd(`SBDSR_IDX_CNT1, 32'h2);
        rd(`SBDSR_IDX_CNT2, 32'h5);
        $display("test count done");
        // two records kept, third lost, every reason code
        wr(`SBDSR_IDX_MASK, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            pa = 2'(i % 3);
            pb = 2'((i + 1) % 3);
            ev(rsn[2 * i], pa);
            ev(rsn[2 * i + 1], pb);
            ev(4'h3, 2'h1);
            chk({31'h0, irq_o}, 32'h1);
            rd(`SBDSR_IDX_PEND, {18'h0, rsn[2 * i + 1], pb, 1'b1,
                rsn[2 * i], pa, 1'b1});
            rd(`SBDSR_IDX_PEND, 32'h0);
            chk({31'h0, irq_o}, 32'h0);
        end
        $display("test drop done");
        // masked: no irq, status still recorded
        wr(`SBDSR_IDX_MASK, 32'h1);
        ev(4'h9, 2'h2);
        chk({31'h0, irq_o}, 32'h0);
        rd(`SBDSR_IDX_PEND, 32'h4D);
        $display("test mask done");
        test_done;
    end
endmodule
bind sbdsr_regs sbdsr_checker chk_u (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .reg_index_i(reg_index_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .rate_drop_i(rate_drop_i),
    .drop_event_i(drop_event_i), .egress_priority_o(egress_priority_o),
    .egress_vlan_id_o(egress_vlan_id_o), .irq_o(irq_o));
